// *** lpdpd_power_down.v ***
`timescale 1ns/1ps
`include "lpdpd_consts.vh"
// How it works
// - Low clock-enable enters power-down immediately.
// - Pending row/refresh work completes before low power.
// - Power-down disables buffers except enable, reset.
// - After tCKELCK, receivers off except reset.
// - No refresh in power-down except self-refresh.
// - High enable exits power-down immediately.
// - Classify idle, active, self-refresh power-down.
// - Enabled termination persists through power-down.
// - Single-ended timing selected per interface bit.
module lpdpd_power_down #(
    parameter CKELCK_NCK = `LPDPD_TCKELCK_NCK
) (
    // Clock and reset
    input wire mclk_i,
    input wire arst_n_i,
    // Link pins
    input wire link_ck_i,
    input wire cke_i,
    // Core status
    input wire banks_open_i,
    input wire self_refresh_i,
    input wire internal_busy_i,
    // Mode bits
    input wire [2:0] odt_enable_i,
    input wire se_clk_i,
    input wire se_wdqs_i,
    input wire se_rdqs_i,
    // Power-down status
    output wire pd_active_o,
    output reg [1:0] pd_kind_o,
    output wire buffers_en_o,
    output reg receivers_en_o,
    output wire low_power_o,
    output wire refresh_allow_o,
    output wire [2:0] odt_term_o,
    output reg se_clk_timing_o,
    output reg se_wdqs_timing_o,
    output reg se_rdqs_timing_o
);

// ----------------------------------------
// Derived counts
// ----------------------------------------
localparam integer NS_CYC = (`LPDPD_TCKELCK_PS + `LPDPD_CLK_PS - 1) / `LPDPD_CLK_PS;
localparam integer HOLD_N = (CKELCK_NCK > NS_CYC) ? CKELCK_NCK : NS_CYC;
localparam [3:0] HOLD_CNT = HOLD_N[3:0];

// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [1:0] ck_sync_reg;
reg [1:0] cke_sync_reg;
reg ck_prev_reg;
wire ck_rise;
wire cke_s;
always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ck_sync_reg <= 2'h0;
        // The enable chain resets to its idle high level, so that the release of
        // reset is not taken for a falling enable and a false power-down entry.
        cke_sync_reg <= 2'h3;
        ck_prev_reg <= 1'b0;
    end else begin
        ck_sync_reg <= {ck_sync_reg[0], link_ck_i};
        cke_sync_reg <= {cke_sync_reg[0], cke_i};
        ck_prev_reg <= ck_sync_reg[1];
    end
end
assign ck_rise = ck_sync_reg[1] & ~ck_prev_reg;
assign cke_s = cke_sync_reg[1];

// ----------------------------------------
// Power-down state
// ----------------------------------------
// The state follows the enable level without waiting for a link clock edge; only the
// receiver shutdown needs counted link clocks and elapsed time.
reg [2:0] state_reg;
reg [2:0] state_next;
reg [3:0] nck_reg;
reg [3:0] nck_next;
reg [3:0] ncyc_reg;
reg [3:0] ncyc_next;
always @* begin
    state_next = state_reg;
    nck_next = nck_reg;
    ncyc_next = ncyc_reg;
    case (state_reg)
        `LPDPD_ST_ACTIVE: begin
            if (!cke_s) begin
                state_next = `LPDPD_ST_HOLD;
                nck_next = 4'h0;
                ncyc_next = 4'h0;
            end
        end
        `LPDPD_ST_HOLD: begin
            if (ck_rise && nck_reg != HOLD_CNT) begin
                nck_next = nck_reg + 4'h1;
            end
            if (ncyc_reg != HOLD_CNT) begin
                ncyc_next = ncyc_reg + 4'h1;
            end
            if (cke_s) begin
                state_next = `LPDPD_ST_ACTIVE;
            end else if (nck_reg == HOLD_CNT && ncyc_reg == HOLD_CNT) begin
                state_next = `LPDPD_ST_PD;
            end
        end
        `LPDPD_ST_PD: begin
            if (cke_s) begin
                state_next = `LPDPD_ST_ACTIVE;
            end
        end
        default: state_next = `LPDPD_ST_ACTIVE;
    endcase
end

always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        state_reg <= `LPDPD_ST_ACTIVE;
        nck_reg <= 4'h0;
        ncyc_reg <= 4'h0;
    end else begin
        state_reg <= state_next;
        nck_reg <= nck_next;
        ncyc_reg <= ncyc_next;
    end
end

// ----------------------------------------
// Mode classification
// ----------------------------------------
// The kind is latched on the entry edge and held for the whole stay, so bank or
// self-refresh status that moves later does not relabel the power-down.
always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        pd_kind_o <= `LPDPD_PD_NONE;
    end else begin
        if (state_reg == `LPDPD_ST_ACTIVE && !cke_s) begin
            if (self_refresh_i) begin
                pd_kind_o <= `LPDPD_PD_SELFREF;
            end else if (banks_open_i) begin
                pd_kind_o <= `LPDPD_PD_ACTIVE;
            end else begin
                pd_kind_o <= `LPDPD_PD_IDLE;
            end
        end else if (state_next == `LPDPD_ST_ACTIVE) begin
            pd_kind_o <= `LPDPD_PD_NONE;
        end
    end
end

// ----------------------------------------
// Receiver shutdown
// ----------------------------------------
// Taken from the next state, so the receivers go off on the edge at which the
// state reaches power-down and come back on the exit edge.
always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        receivers_en_o <= 1'b1;
    end else begin
        receivers_en_o <= (state_next != `LPDPD_ST_PD);
    end
end

// ----------------------------------------
// Single-ended timing select
// ----------------------------------------
// Each interface follows its own mode bit; one register stage keeps these
// selects glitch free while the mode bits are being rewritten.
always @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        se_clk_timing_o <= 1'b0;
        se_wdqs_timing_o <= 1'b0;
        se_rdqs_timing_o <= 1'b0;
    end else begin
        se_clk_timing_o <= se_clk_i;
        se_wdqs_timing_o <= se_wdqs_i;
        se_rdqs_timing_o <= se_rdqs_i;
    end
end

// ----------------------------------------
// Power-down status
// ----------------------------------------
assign pd_active_o = (state_reg != `LPDPD_ST_ACTIVE);
assign buffers_en_o = ~pd_active_o;
// Power-down current is only reached once activate, precharge or refresh work
// that was still running at entry has drained.
// low power after pending work
assign low_power_o = pd_active_o & ~internal_busy_i;
assign refresh_allow_o = ~pd_active_o | (pd_kind_o == `LPDPD_PD_SELFREF);
// Termination does not follow the power state, because the bus that it loads
// may still be driven towards other ranks.
// termination kept in all states
assign odt_term_o = odt_enable_i;

endmodule

// *** lpdpd_consts.vh ***
`ifndef LPDPD_CONSTS_VH
`define LPDPD_CONSTS_VH
// ----------------------------------------
// Power-down state encodings
// ----------------------------------------
`define LPDPD_ST_ACTIVE 3'h0
`define LPDPD_ST_HOLD 3'h1
`define LPDPD_ST_PD 3'h2
`define LPDPD_ST_EXIT 3'h3
`define LPDPD_PD_NONE 2'h0
`define LPDPD_PD_IDLE 2'h1
`define LPDPD_PD_ACTIVE 2'h2
`define LPDPD_PD_SELFREF 2'h3
// ----------------------------------------
// Timing figures (ps and link clock counts)
// ----------------------------------------
`define LPDPD_CLK_PS 10000
`define LPDPD_TCKELCK_PS 5000
`define LPDPD_TCKELCK_NCK 5
// ----------------------------------------
// Termination mode bit positions
// ----------------------------------------
`define LPDPD_ODT_CA_BIT 0
`define LPDPD_ODT_CK_BIT 1
`define LPDPD_ODT_CS_BIT 2
`endif

// *** lpdpd_host_model.sv ***
`timescale 1ns/1ps
module lpdpd_host_model (
    // Request from the bench
    input wire pd_req_i,
    // Link pins
    output logic cke_o,
    output logic ck_o
);
    // Levels are awaited, not edges, so a request that moves while the clock
    // is still being held on is never missed.
    initial begin
        cke_o = 1'b1;
        ck_o = 1'b0;
        forever begin
            wait (pd_req_i);
            // no command is in flight at the fall.
            #3 cke_o = 1'b0;
            // six steady clocks cover tCKELCK and tCKELCS.
            repeat (12) #80 ck_o = ~ck_o;
            // enable stays low until the request is released.
            wait (!pd_req_i);
            #3;
            // four steady clocks before the rise.
            repeat (8) #80 ck_o = ~ck_o;
            cke_o = 1'b1;
            // enable held high for tXP in whole clocks.
            repeat (10) #80 ck_o = ~ck_o;
        end
    end
endmodule

// *** lpdpd_checker.sv ***
`timescale 1ns/1ps
module lpdpd_checker (
    input wire mclk_i, arst_n_i, cke_i, banks_open_i, self_refresh_i, internal_busy_i,
    input wire se_clk_i, se_wdqs_i, se_rdqs_i, pd_active_o, buffers_en_o,
    input wire receivers_en_o, low_power_o, refresh_allow_o,
    input wire se_clk_timing_o, se_wdqs_timing_o, se_rdqs_timing_o,
    input wire [1:0] pd_kind_o,
    input wire [2:0] odt_enable_i, odt_term_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    a_pd_entry: assert property ($fell(cke_i) |-> ##[1:4] pd_active_o)
        else $error("entry");
    a_pd_exit: assert property ($rose(cke_i) |-> ##[1:4] (!pd_active_o && buffers_en_o))
        else $error("exit");
    a_rx_off: assert property ($fell(cke_i) |-> ##[5:300] !receivers_en_o)
        else $error("rx");
    a_pd_kind: assert property ($rose(pd_active_o) && !cke_i
        |-> pd_kind_o == (self_refresh_i ? 2'h3 : banks_open_i ? 2'h2 : 2'h1))
        else $error("kind");
    a_low_pwr: assert property (pd_active_o |-> low_power_o == !internal_busy_i)
        else $error("lp");
    a_no_refresh: assert property (pd_active_o && !receivers_en_o
        |-> refresh_allow_o == (pd_kind_o == 2'h3)) else $error("refresh");
    a_odt_kept: assert property (odt_term_o == odt_enable_i) else $error("odt");
    a_se_delay: assert property ({se_clk_timing_o, se_wdqs_timing_o, se_rdqs_timing_o}
        == $past({se_clk_i, se_wdqs_i, se_rdqs_i})) else $error("se");
endmodule
bind lpdpd_power_down lpdpd_checker chk (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cke_i(cke_i),
    .banks_open_i(banks_open_i),
    .self_refresh_i(self_refresh_i),
    .internal_busy_i(internal_busy_i),
    .se_clk_i(se_clk_i),
    .se_wdqs_i(se_wdqs_i),
    .se_rdqs_i(se_rdqs_i),
    .pd_active_o(pd_active_o),
    .buffers_en_o(buffers_en_o),
    .receivers_en_o(receivers_en_o),
    .low_power_o(low_power_o),
    .refresh_allow_o(refresh_allow_o),
    .se_clk_timing_o(se_clk_timing_o),
    .se_wdqs_timing_o(se_wdqs_timing_o),
    .se_rdqs_timing_o(se_rdqs_timing_o),
    .pd_kind_o(pd_kind_o),
    .odt_enable_i(odt_enable_i),
    .odt_term_o(odt_term_o)
);

// *** tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic mclk_i, arst_n_i, banks_open_i, self_refresh_i, internal_busy_i, pd_req;
    logic se_clk_i, se_wdqs_i, se_rdqs_i;
    logic [2:0] odt_enable_i;
    wire link_ck_i, cke_i, pd_active_o, buffers_en_o, receivers_en_o, low_power_o;
    wire refresh_allow_o, se_clk_timing_o, se_wdqs_timing_o, se_rdqs_timing_o;
    wire [1:0] pd_kind_o;
    wire [2:0] odt_term_o;
    wire [5:0] pd_view = {receivers_en_o, buffers_en_o, low_power_o, refresh_allow_o, pd_kind_o};
    int mismatches, n_compared;
    lpdpd_host_model host (.pd_req_i(pd_req), .cke_o(cke_i), .ck_o(link_ck_i));
    lpdpd_power_down dut (
        .mclk_i(mclk_i),
        .arst_n_i(arst_n_i),
        .link_ck_i(link_ck_i),
        .cke_i(cke_i),
        .banks_open_i(banks_open_i),
        .self_refresh_i(self_refresh_i),
        .internal_busy_i(internal_busy_i),
        .odt_enable_i(odt_enable_i),
        .se_clk_i(se_clk_i),
        .se_wdqs_i(se_wdqs_i),
        .se_rdqs_i(se_rdqs_i),
        .pd_active_o(pd_active_o),
        .pd_kind_o(pd_kind_o),
        .buffers_en_o(buffers_en_o),
        .receivers_en_o(receivers_en_o),
        .low_power_o(low_power_o),
        .refresh_allow_o(refresh_allow_o),
        .odt_term_o(odt_term_o),
        .se_clk_timing_o(se_clk_timing_o),
        .se_wdqs_timing_o(se_wdqs_timing_o),
        .se_rdqs_timing_o(se_rdqs_timing_o)
    );
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task chk(input string w, input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", w, e, s);
        end
    endtask
    task wait_rx(input logic v);
        for (int i = 0; i < 400 && receivers_en_o !== v; i++) @(negedge mclk_i);
    endtask
    task scen_pd(input logic b, s, input logic [1:0] k);
        @(posedge mclk_i);
        {banks_open_i, self_refresh_i, internal_busy_i, pd_req} <= {b, s, b, 1'b1};
        {odt_enable_i, se_clk_i, se_wdqs_i, se_rdqs_i} <= {k, b, s, b, s};
        wait_rx(1'b0);
        chk("entry", pd_view, {2'b00, ~b, s, k});
        chk("active", {7'h00, pd_active_o}, 8'h01);
        chk("odt pd", {5'h00, odt_term_o}, {5'h00, k, b});
        chk("se", {5'h00, se_clk_timing_o, se_wdqs_timing_o, se_rdqs_timing_o}, {5'h00, s, b, s});
        @(posedge mclk_i);
        internal_busy_i <= 1'b0;
        @(negedge mclk_i);
        chk("drained", {7'h00, low_power_o}, 8'h01);
        @(posedge mclk_i);
        pd_req <= 1'b0;
        wait_rx(1'b1);
        chk("exit", pd_view, 8'h34);
        chk("left", {7'h00, pd_active_o}, 8'h00);
        chk("odt run", {5'h00, odt_term_o}, {5'h00, k, b});
        $display("scenario %0d done", k);
    endtask
    task tally_and_finish;
        $display("checks %0d bad %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        {arst_n_i, banks_open_i, self_refresh_i, internal_busy_i, pd_req} = 5'h00;
        {odt_enable_i, se_clk_i, se_wdqs_i, se_rdqs_i} = 6'h00;
        repeat (2) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        scen_pd(1'b0, 1'b0, 2'h1);
        scen_pd(1'b1, 1'b0, 2'h2);
        scen_pd(1'b0, 1'b1, 2'h3);
        tally_and_finish;
    end
    initial begin
        // Three scenarios take under 10 us; twice that leaves ample margin.
        #20000;
        mismatches++;
        tally_and_finish;
    end
endmodule
